/* File: design/machine_check_status_unit.v */
`timescale 1ns/1ps
`default_nettype none
`include "mcheck_defines.vh"
module machine_check_status_unit (
  // Clock and reset
  input  wire        CORE_CLK,
  input  wire        RSTN,
  // Special register access port
  input  wire        SPR_WR,
  input  wire        SPR_RD,
  input  wire [9:0]  SPR_NUM,
  input  wire [31:0] SPR_WDATA,
  input  wire        SUPERVISOR,
  output reg  [31:0] SPR_RDATA,
  output reg         SPR_PRIV_FAULT,
  // Error sources, one-cycle pulses from core logic
  input  wire        INSTR_READ_BUS_ERROR,
  input  wire        DATA_READ_BUS_ERROR,
  input  wire        DATA_WRITE_BUS_ERROR,
  input  wire        TRANSLATION_PARITY_ERROR,
  input  wire        INSTR_CACHE_PARITY_ERROR,
  input  wire        DCACHE_SEARCH_PARITY_ERROR,
  input  wire        DCACHE_FLUSH_PARITY_ERROR,
  // Core state
  input  wire [31:0] MACHINE_STATE,
  input  wire [31:0] CURRENT_PC,
  input  wire        INT_ACCEPT,
  // Interrupt request and vector
  output reg         MCHECK_INT_REQ,
  output reg  [31:0] MCHECK_VECTOR
);
  ////////////////////////////////////////////////////////////////////
  reg  [31:0] cause_r;
  reg  [31:0] cause_nxt;
  reg  [31:0] ret_addr_r;
  reg  [31:0] saved_state_r;
  reg  [15:0] prefix_r;
  reg  [11:0] offset_r [0:15];
  reg  [31:0] rdata_nxt;
  wire [6:0]  cause_in;
  wire        check_evt;
  wire        me;
  wire        take_int;
  wire        wr_ok;
  wire        rd_ok;
  wire        off_hit;
  wire [3:0]  off_idx;
  wire        sel_cause;
  wire        sel_ret;
  wire        sel_state;
  wire        sel_prefix;
  wire        set_imprecise;
  wire [31:0] clr_mask;

  // Cause vector runs from status bit 1 at the top down to status bit 7
  assign cause_in[6] = INSTR_READ_BUS_ERROR;
  assign cause_in[5] = DATA_READ_BUS_ERROR;
  assign cause_in[4] = DATA_WRITE_BUS_ERROR;
  assign cause_in[3] = TRANSLATION_PARITY_ERROR;
  assign cause_in[2] = INSTR_CACHE_PARITY_ERROR;
  assign cause_in[1] = DCACHE_SEARCH_PARITY_ERROR;
  assign cause_in[0] = DCACHE_FLUSH_PARITY_ERROR;
  assign check_evt = |cause_in;
  assign me        = MACHINE_STATE[`ME_BIT];
  assign wr_ok     = SPR_WR & SUPERVISOR;
  assign rd_ok     = SPR_RD & SUPERVISOR;
  assign off_hit   = (SPR_NUM >= `SPRN_OFFSET_BASE) && (SPR_NUM <= `SPRN_OFFSET_LAST);
  assign off_idx   = SPR_NUM[3:0];
  assign take_int  = INT_ACCEPT & cause_r[`BIT_PENDING] & me;

  // Register selects for the write paths; the read decode compares SPR_NUM directly
  assign sel_cause  = (SPR_NUM == `SPRN_CAUSE);
  assign sel_ret    = (SPR_NUM == `SPRN_RET_ADDR);
  assign sel_state  = (SPR_NUM == `SPRN_SAVED_STATE);
  assign sel_prefix = (SPR_NUM == `SPRN_PREFIX);

  // Write-one-to-clear mask; zero unless a privileged write hits the cause register
  assign clr_mask      = (wr_ok && sel_cause) ? SPR_WDATA : `ZERO_32;
  // A check that arrives while masked can only be handled late
  assign set_imprecise = check_evt & ~me;

  ////////////////////////////////////////////////////////////////////
  // Software clear applies first; a new event in the same cycle wins, so a
  // handler that clears the status cannot lose a check arriving meanwhile
  always @* begin
    cause_nxt = cause_r & ~clr_mask;
    if (check_evt) begin
      // Summary and cause bits are set on the same edge
      cause_nxt[`BIT_PENDING] = 1'b1;
      cause_nxt[`CAUSE_HI:`CAUSE_LO] = cause_nxt[`CAUSE_HI:`CAUSE_LO] | cause_in;
    end
    if (set_imprecise) begin
      cause_nxt[`BIT_IMPRECISE] = 1'b1;
    end
    // Reserved bits never hold state
    cause_nxt[`STATUS_LO-1:0] = {`STATUS_LO{1'b0}};
  end

  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      cause_r <= `ZERO_32;
    end else begin
      cause_r <= cause_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Return address: hardware capture takes priority over a software write,
  // so the handler always sees the address of the interrupted flow
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      ret_addr_r <= `ZERO_32;
    end else if (take_int) begin
      ret_addr_r <= {CURRENT_PC[31:`RETADDR_LO], 2'b00};
    end else if (wr_ok && sel_ret) begin
      ret_addr_r <= {SPR_WDATA[31:`RETADDR_LO], 2'b00};
    end
  end

  // Saved machine state: same priority as the return address
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      saved_state_r <= `ZERO_32;
    end else if (take_int) begin
      saved_state_r <= MACHINE_STATE;
    end else if (wr_ok && sel_state) begin
      saved_state_r <= SPR_WDATA;
    end
  end

  // Vector prefix: changed by software only
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      prefix_r <= `ZERO_16;
    end else if (wr_ok && sel_prefix) begin
      prefix_r <= SPR_WDATA[31:`PREFIX_LO];
    end
  end

  ////////////////////////////////////////////////////////////////////
  // One offset register per interrupt type; only entry 1 feeds the vector here
  genvar g;
  generate
    for (g = 0; g < 16; g = g + 1) begin : g_off
      localparam [3:0] ENTRY = g;
      always @(posedge CORE_CLK or negedge RSTN) begin
        if (!RSTN) begin
          offset_r[g] <= 12'h000;
        end else if (wr_ok && off_hit && off_idx == ENTRY) begin
          offset_r[g] <= SPR_WDATA[`OFFSET_HI:`OFFSET_LO];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////
  // Read decode; unmapped or unprivileged reads return zero
  always @* begin
    rdata_nxt = `ZERO_32;
    if (!rd_ok) begin
      rdata_nxt = `ZERO_32;
    end else if (SPR_NUM == `SPRN_CAUSE) begin
      rdata_nxt = cause_r;
    end else if (SPR_NUM == `SPRN_RET_ADDR) begin
      rdata_nxt = ret_addr_r;
    end else if (SPR_NUM == `SPRN_SAVED_STATE) begin
      rdata_nxt = saved_state_r;
    end else if (SPR_NUM == `SPRN_PREFIX) begin
      rdata_nxt = {prefix_r, `ZERO_16};
    end else if (off_hit) begin
      rdata_nxt = {16'h0000, offset_r[off_idx], 4'h0};
    end
  end

  ////////////////////////////////////////////////////////////////////
  // Read data stands for one cycle only, then returns to zero
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      SPR_RDATA <= `ZERO_32;
    end else begin
      SPR_RDATA <= rdata_nxt;
    end
  end

  // Fault flags any unprivileged access, read or write alike
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      SPR_PRIV_FAULT <= 1'b0;
    end else begin
      SPR_PRIV_FAULT <= (SPR_RD | SPR_WR) & ~SUPERVISOR;
    end
  end

  // Request follows the next pending value so it rises on the event edge
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      MCHECK_INT_REQ <= 1'b0;
    end else begin
      MCHECK_INT_REQ <= cause_nxt[`BIT_PENDING] & me;
    end
  end

  // Registered so the output comes from a flip-flop;
  // it lags a prefix or offset write by one cycle
  always @(posedge CORE_CLK or negedge RSTN) begin
    if (!RSTN) begin
      MCHECK_VECTOR <= `ZERO_32;
    end else begin
      MCHECK_VECTOR <= {prefix_r, offset_r[`MC_OFFSET_IDX], 4'h0};
    end
  end
endmodule // machine_check_status_unit
`default_nettype wire

/* File: design/mcheck_defines.vh */
// Function
// - An asynchronous machine check sets the summary pending bit 0.
// - With the summary bit, one cause bit from 1 to 7 sets too.
// - Machine check interrupt is taken when enable and pending bit are set.
// - Bus error on instruction read, data read, data write sets bit 1, 2, 3.
// - Translation parity sets bit 4, instruction cache parity sets bit 5.
// - Bit 6 sets only for data cache parity found during a search.
// - Bit 7 sets only for data cache parity found during a flush.
// - Bit 8 sets when a check hits while machine check enable is 0.
// - Cause status at register 0x23C, supervisor read and clear; bits 9-31 reserved.
// - Interrupt saves return address in bits 0-29; bits 30-31 reserved.
// - Interrupt copies full 32-bit machine state into the saved state register.
// - Vector prefix register holds 16-bit prefix in bits 0-15; rest reserved.
// - Vector prefix register at 0x03F, supervisor read and write only.
// - Offset registers keep the 12-bit offset in bits 16-27.
`ifndef MCHECK_DEFINES_VH
`define MCHECK_DEFINES_VH
`define SPRN_RET_ADDR    10'h023A
`define SPRN_SAVED_STATE 10'h023B
`define SPRN_CAUSE       10'h023C
`define SPRN_PREFIX      10'h003F
`define SPRN_OFFSET_BASE 10'h0190
`define SPRN_OFFSET_LAST 10'h019F
// Bit positions use LSB-0 numbering: documented bit n is [31-n]
`define BIT_PENDING      31
`define BIT_IMPRECISE    23
`define CAUSE_HI         30
`define CAUSE_LO         24
`define STATUS_LO        23
`define RETADDR_LO       2
`define PREFIX_LO        16
`define OFFSET_HI        15
`define OFFSET_LO        4
`define ME_BIT           12
`define MC_OFFSET_IDX    4'h1
`define ZERO_32          32'h0000_0000
`define ZERO_16          16'h0000
`endif

/* File: test/mcheck_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module mcheck_chk (
  // Clock, reset and register port
  input wire logic        CORE_CLK, RSTN, SPR_WR, SPR_RD, SUPERVISOR,
  input wire logic [9:0]  SPR_NUM,
  input wire logic [31:0] SPR_RDATA, MACHINE_STATE, MCHECK_VECTOR,
  input wire logic        SPR_PRIV_FAULT, MCHECK_INT_REQ,
  // Error sources
  input wire logic        INSTR_READ_BUS_ERROR, DATA_READ_BUS_ERROR, DATA_WRITE_BUS_ERROR,
  input wire logic        TRANSLATION_PARITY_ERROR, INSTR_CACHE_PARITY_ERROR,
  input wire logic        DCACHE_SEARCH_PARITY_ERROR, DCACHE_FLUSH_PARITY_ERROR
);
  wire ev = |{INSTR_READ_BUS_ERROR, DATA_READ_BUS_ERROR, DATA_WRITE_BUS_ERROR, TRANSLATION_PARITY_ERROR,
              INSTR_CACHE_PARITY_ERROR, DCACHE_SEARCH_PARITY_ERROR, DCACHE_FLUSH_PARITY_ERROR};
  wire srd = SPR_RD && SUPERVISOR;
  default clocking @(posedge CORE_CLK); endclocking
  default disable iff (!RSTN);
  AST_PRIV: assert property ((SPR_RD || SPR_WR) && !SUPERVISOR |=> SPR_PRIV_FAULT && SPR_RDATA == 32'h0)
    else $error("unprivileged access not refused");
  AST_NOFAULT: assert property (!SPR_RD && !SPR_WR |=> !SPR_PRIV_FAULT) else $error("fault without access");
  AST_IDLE: assert property (!SPR_RD |=> SPR_RDATA == 32'h0) else $error("read data without read");
  AST_REQ: assert property (ev && MACHINE_STATE[12] |=> MCHECK_INT_REQ) else $error("no request");
  AST_NOREQ: assert property (!MACHINE_STATE[12] |=> !MCHECK_INT_REQ) else $error("request while masked");
  AST_PFX: assert property (srd && SPR_NUM == 10'h03F |=> SPR_RDATA[15:0] == 16'h0)
    else $error("prefix reserved bits set");
  AST_CAUSE: assert property (srd && SPR_NUM == 10'h23C |=> SPR_RDATA[22:0] == 23'h0)
    else $error("cause reserved bits set");
  AST_RET: assert property (srd && SPR_NUM == 10'h23A |=> SPR_RDATA[1:0] == 2'h0)
    else $error("return address reserved bits set");
  AST_VEC: assert property (MCHECK_VECTOR[3:0] == 4'h0) else $error("vector low bits set");
endmodule // mcheck_chk
`default_nettype wire

/* File: test/tb_machine_check_status_unit.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_machine_check_status_unit;
  logic        CORE_CLK = 0, RSTN = 0, SPR_WR = 0, SPR_RD = 0, SUPERVISOR = 1, INT_ACCEPT = 0;
  logic [9:0]  SPR_NUM = 0;
  logic [31:0] SPR_WDATA = 0, MACHINE_STATE = 0, CURRENT_PC = 0;
  logic [6:0]  ev = 0;
  wire  [31:0] SPR_RDATA, MCHECK_VECTOR;
  wire         SPR_PRIV_FAULT, MCHECK_INT_REQ;
  int          err_count = 0, n_checks = 0;
  // Names match the ports so the rest connects by name
  machine_check_status_unit u_machine_check_status_unit (.INSTR_READ_BUS_ERROR(ev[0]),
    .DATA_READ_BUS_ERROR(ev[1]), .DATA_WRITE_BUS_ERROR(ev[2]), .TRANSLATION_PARITY_ERROR(ev[3]),
    .INSTR_CACHE_PARITY_ERROR(ev[4]), .DCACHE_SEARCH_PARITY_ERROR(ev[5]), .DCACHE_FLUSH_PARITY_ERROR(ev[6]), .*);
  ////////////////////////////////////////////////////////////
  task automatic check(string w, logic [31:0] seen, logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", w, exp, seen);
    end
  endtask
  task automatic wr(logic [9:0] n, logic [31:0] d);
    @(negedge CORE_CLK) {SPR_WR, SPR_NUM, SPR_WDATA} = {1'b1, n, d};
    @(negedge CORE_CLK) SPR_WR = 0;
  endtask
  // Read data stands one cycle, so it is taken at the next falling edge
  task automatic rdc(string w, logic [9:0] n, logic [31:0] exp);
    @(negedge CORE_CLK) {SPR_RD, SPR_NUM} = {1'b1, n};
    @(negedge CORE_CLK) SPR_RD = 0;
    check(w, SPR_RDATA, exp);
  endtask
  task automatic pulse(int i);
    @(negedge CORE_CLK) ev = 7'h01 << i;
    @(negedge CORE_CLK) ev = 0;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_causes();
    for (int i = 0; i < 7; i++) begin
      pulse(i);
      rdc("cause", 10'h23C, 32'h8080_0000 | (32'h4000_0000 >> i));
      wr(10'h23C, 32'hFFFF_FFFF);
      rdc("cleared", 10'h23C, 32'h0);
    end
  endtask
  task automatic t_int();
    {MACHINE_STATE, CURRENT_PC} = {32'h0000_1005, 32'h1234_567B};
    pulse(1);
    check("req", {31'h0, MCHECK_INT_REQ}, 32'h1);
    INT_ACCEPT = 1;
    @(negedge CORE_CLK) {INT_ACCEPT, MACHINE_STATE, CURRENT_PC} = 0;
    rdc("ret", 10'h23A, 32'h1234_5678);
    rdc("state", 10'h23B, 32'h0000_1005);
    rdc("precise", 10'h23C, 32'hA000_0000);
    wr(10'h23C, 32'hFFFF_FFFF);
  endtask
  task automatic t_vec();
    wr(10'h03F, 32'hABCD_FFFF);
    wr(10'h191, 32'hFFFF_0123);
    rdc("prefix", 10'h03F, 32'hABCD_0000);
    check("vector", MCHECK_VECTOR, 32'hABCD_0120);
  endtask
  task automatic t_priv();
    @(negedge CORE_CLK) SUPERVISOR = 0;
    wr(10'h03F, 32'h1111_0000);
    check("fault", {31'h0, SPR_PRIV_FAULT}, 32'h1);
    rdc("user read", 10'h03F, 32'h0);
    @(negedge CORE_CLK) SUPERVISOR = 1;
    rdc("kept", 10'h03F, 32'hABCD_0000);
  endtask
  task automatic t_race();
    @(negedge CORE_CLK) {SPR_WR, SPR_NUM, SPR_WDATA, ev} = {1'b1, 10'h23C, 32'hFFFF_FFFF, 7'h04};
    @(negedge CORE_CLK) {SPR_WR, ev} = 0;
    rdc("set wins", 10'h23C, 32'h9080_0000);
    wr(10'h23C, 32'h0080_0000);
    rdc("partial clear", 10'h23C, 32'h9000_0000);
    @(negedge CORE_CLK) RSTN = 0;
    @(negedge CORE_CLK) RSTN = 1;
    rdc("reset cause", 10'h23C, 32'h0);
    rdc("reset prefix", 10'h03F, 32'h0);
    check("reset vector", MCHECK_VECTOR, 32'h0);
  endtask
  ////////////////////////////////////////////////////////////
  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial forever #5 CORE_CLK = ~CORE_CLK;
  // Whole run is about a hundred cycles; the limit leaves wide margin
  initial begin
    #100000;
    err_count++;
    complete_run();
  end
  initial begin
    repeat (4) @(negedge CORE_CLK);
    RSTN = 1;
    rdc("cause reset", 10'h23C, 32'h0);
    t_causes();
    t_int();
    t_vec();
    t_priv();
    t_race();
    complete_run();
  end
endmodule // tb_machine_check_status_unit
bind machine_check_status_unit mcheck_chk u_mcheck_chk (.*);
`default_nettype wire
